// *** rtl/ccbt_consts.vh ***
`ifndef CCBT_CONSTS_VH
`define CCBT_CONSTS_VH
// ----------------------------------------
// register word offsets (byte address = 4 * index)
// ----------------------------------------
`define CCBT_IDX_COUNTER 4'h0
`define CCBT_IDX_CTRL0 4'h1
`define CCBT_IDX_CTRL1 4'h2
`define CCBT_IDX_DIVIDER 4'h3
`define CCBT_IDX_RESETCMP 4'h4
`define CCBT_IDX_CH0CMP 4'h5
`define CCBT_IDX_CH0WAVE 4'h6
`define CCBT_IDX_FUNC 4'h7
`define CCBT_IDX_STATUS 4'h8
`define CCBT_IDX_PRESC 4'h9
// ----------------------------------------
// control 0 fields
// ----------------------------------------
`define CCBT_C0_SRC_LO 0
`define CCBT_C0_SRC_HI 1
`define CCBT_C0_RSTREG 2
`define CCBT_C0_OVSEL 3
// ----------------------------------------
// control 1 fields
// ----------------------------------------
`define CCBT_C1_RUN 0
`define CCBT_C1_CH0RST 1
`define CCBT_C1_EXTRST 2
`define CCBT_C1_DIR_LO 3
`define CCBT_C1_DIR_HI 4
// ----------------------------------------
// channel 0 waveform control fields
// ----------------------------------------
`define CCBT_W_MODE_LO 0
`define CCBT_W_MODE_HI 1
`define CCBT_W_INV 2
`define CCBT_W_LVL 3
// ----------------------------------------
// function / status / prescale fields
// ----------------------------------------
`define CCBT_F_SEL 0
`define CCBT_F_EN 1
`define CCBT_S_IRQ 0
`define CCBT_P_EN 8
// ----------------------------------------
// encodings and values
// ----------------------------------------
`define CCBT_SRC_STOP 2'b00
`define CCBT_SRC_F1 2'b01
`define CCBT_SRC_QUAD 2'b10
`define CCBT_DIR_UP 2'b00
`define CCBT_DIR_UPDN 2'b01
`define CCBT_DIR_QUAD 2'b10
`define CCBT_WAVE_SINGLE 2'b00
`define CCBT_WAVE_SR 2'b11
`define CCBT_ZERO16 16'h0000
`define CCBT_MAX16 16'hffff
`define CCBT_OV_BIT14 14
`define CCBT_OV_BIT15 15
`define CCBT_CH0_DELAY 2'h2
`endif

// *** rtl/ccbt_divider.v ***
`timescale 1ns/1ps
`include "ccbt_consts.vh"
module ccbt_divider #(
    parameter W = 8
) (
    input wire core_clk,
    input wire rst,
    input wire clear,
    input wire tick_in,
    input wire [W-1:0] divide,
    output reg tick_out
);
    reg [W-1:0] cnt_reg;
    // ----------------------------------------
    // divide ticks by divide+1
    // ----------------------------------------
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_reg <= {W{1'b0}};
            tick_out <= 1'b0;
        end
        else if (clear)
        begin
            cnt_reg <= {W{1'b0}};
            tick_out <= 1'b0;
        end
        else
        begin
            tick_out <= 1'b0;
            if (tick_in)
            begin
                if (cnt_reg >= divide)
                begin
                    cnt_reg <= {W{1'b0}};
                    tick_out <= 1'b1;
                end
                else
                    cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // ccbt_divider

// *** rtl/ccbt_quad.v ***
`timescale 1ns/1ps
module ccbt_quad (
    input wire core_clk,
    input wire rst,
    input wire a_in,
    input wire b_in,
    output reg a_s,
    output reg step,
    output reg down
);
    reg a_m;
    reg b_m;
    reg b_s;
    reg a_d;
    reg b_d;
    // ----------------------------------------
    // sync and decode quadrature edges
    // ----------------------------------------
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            a_m <= 1'b0;
            b_m <= 1'b0;
            a_s <= 1'b0;
            b_s <= 1'b0;
            a_d <= 1'b0;
            b_d <= 1'b0;
            step <= 1'b0;
            down <= 1'b0;
        end
        else
        begin
            a_m <= a_in;
            b_m <= b_in;
            a_s <= a_m;
            b_s <= b_m;
            a_d <= a_s;
            b_d <= b_s;
            step <= (a_s ^ a_d) ^ (b_s ^ b_d);
            // a leads b: up; b leads a: down
            // direction held until the next edge so a divided tick sees it
            if ((a_s ^ a_d) | (b_s ^ b_d))
                down <= (a_s ^ a_d) ? (a_s == b_s) : (a_s != b_s);
        end
    end
endmodule // ccbt_quad

// *** rtl/ccbt_base_timer.v ***
`timescale 1ns/1ps
`include "ccbt_consts.vh"
module ccbt_base_timer #(
    parameter DIV_W = 8
) (
    input wire core_clk,
    input wire rst,
    input wire [5:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire ext_reset_pin,
    input wire quad_input_a,
    input wire quad_input_b,
    output reg timer_irq,
    output reg chan0_out,
    output reg chan1_out,
    output reg capture_tick
);
    reg [15:0] timer_counter_value;
    reg [1:0] count_source_sel;
    reg reset_reg_reset_en;
    reg overflow_bit_sel;
    reg timer_run;
    reg chan0_match_reset_en;
    reg ext_pin_reset_en;
    reg [1:0] count_direction_mode;
    reg [DIV_W-1:0] divide_setting;
    reg [15:0] reset_compare_value;
    reg [15:0] chan0_compare_value;
    reg [1:0] waveform_mode;
    reg output_invert_en;
    reg default_level;
    reg chan_function_sel;
    reg chan_enable;
    reg [1:0] chan1_mode_reg;
    reg [DIV_W-1:0] presc_div_reg;
    reg prescale_en;
    reg irq_flag_reg;
    reg dn_reg;
    reg [1:0] ch0_pend_reg;
    reg ext_m_reg;
    reg ext_s_reg;
    reg wave_reg;
    reg [DIV_W-1:0] presc_cnt_reg;
    reg ack_reg;
    reg [15:0] cnt_next;
    reg dn_next;
    reg reset_hit;
    reg irq_set;
    wire a_sync;
    wire q_step;
    wire q_down;
    wire bt_tick;
    wire src_tick;
    wire running;
    wire acc;
    wire [3:0] idx;
    wire wr;
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function sel_hit;
        input [3:0] a;
        input [3:0] b;
        begin
            sel_hit = (a == b);
        end
    endfunction
    assign acc = (avs_read | avs_write) & ~ack_reg;
    assign idx = avs_address[5:2];
    assign wr = avs_write & ~ack_reg & avs_byteenable[0];
    assign running = timer_run & (count_source_sel != `CCBT_SRC_STOP);
    // ----------------------------------------
    // count source
    // ----------------------------------------
    ccbt_quad u_quad (
        .core_clk(core_clk),
        .rst(rst),
        .a_in(quad_input_a),
        .b_in(quad_input_b),
        .a_s(a_sync),
        .step(q_step),
        .down(q_down)
    );
    assign src_tick = (count_source_sel == `CCBT_SRC_QUAD) ? q_step : 1'b1;
    ccbt_divider #(.W(DIV_W)) u_div (
        .core_clk(core_clk),
        .rst(rst),
        .clear(~running),
        .tick_in(src_tick),
        .divide(divide_setting),
        .tick_out(bt_tick)
    );
    // ----------------------------------------
    // next count
    // ----------------------------------------
    always @*
    begin
        cnt_next = timer_counter_value;
        dn_next = dn_reg;
        reset_hit = 1'b0;
        irq_set = 1'b0;
        if (bt_tick)
        begin
            case (count_direction_mode)
                `CCBT_DIR_UPDN:
                begin
                    if (!dn_reg && timer_counter_value == `CCBT_MAX16)
                    begin
                        dn_next = 1'b1;
                        cnt_next = timer_counter_value - 16'h0001;
                    end
                    else if (dn_reg && timer_counter_value == `CCBT_ZERO16)
                    begin
                        dn_next = 1'b0;
                        cnt_next = timer_counter_value + 16'h0001;
                    end
                    else if (dn_reg)
                        cnt_next = timer_counter_value - 16'h0001;
                    else
                        cnt_next = timer_counter_value + 16'h0001;
                end
                `CCBT_DIR_QUAD:
                    cnt_next = q_down ? timer_counter_value - 16'h0001
                        : timer_counter_value + 16'h0001;
                default:
                    cnt_next = timer_counter_value + 16'h0001;
            endcase
            if (overflow_bit_sel ? (timer_counter_value[`CCBT_OV_BIT15] & ~cnt_next[`CCBT_OV_BIT15])
                : (timer_counter_value[`CCBT_OV_BIT14] & ~cnt_next[`CCBT_OV_BIT14]))
                irq_set = 1'b1;
            if (reset_reg_reset_en && timer_counter_value == reset_compare_value)
            begin
                reset_hit = 1'b1;
                irq_set = 1'b1;
            end
            if (ch0_pend_reg == `CCBT_CH0_DELAY)
                reset_hit = 1'b1;
        end
        if (ext_pin_reset_en && !ext_s_reg)
            reset_hit = 1'b1;
        if (reset_hit)
            cnt_next = `CCBT_ZERO16;
    end
    // ----------------------------------------
    // timer and registers
    // ----------------------------------------
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            timer_counter_value <= `CCBT_ZERO16;
            count_source_sel <= `CCBT_SRC_STOP;
            reset_reg_reset_en <= 1'b0;
            overflow_bit_sel <= 1'b0;
            timer_run <= 1'b0;
            chan0_match_reset_en <= 1'b0;
            ext_pin_reset_en <= 1'b0;
            count_direction_mode <= `CCBT_DIR_UP;
            divide_setting <= {DIV_W{1'b0}};
            reset_compare_value <= `CCBT_ZERO16;
            chan0_compare_value <= `CCBT_ZERO16;
            waveform_mode <= `CCBT_WAVE_SINGLE;
            output_invert_en <= 1'b0;
            default_level <= 1'b0;
            chan_function_sel <= 1'b0;
            chan_enable <= 1'b0;
            chan1_mode_reg <= `CCBT_WAVE_SINGLE;
            presc_div_reg <= {DIV_W{1'b0}};
            prescale_en <= 1'b0;
            irq_flag_reg <= 1'b0;
            dn_reg <= 1'b0;
            ch0_pend_reg <= 2'h0;
            ext_m_reg <= 1'b1;
            ext_s_reg <= 1'b1;
            ack_reg <= 1'b0;
        end
        else
        begin
            ext_m_reg <= ext_reset_pin;
            ext_s_reg <= ext_m_reg;
            ack_reg <= acc;
            if (!timer_run)
            begin
                timer_counter_value <= `CCBT_ZERO16;
                dn_reg <= 1'b0;
                ch0_pend_reg <= 2'h0;
            end
            else if (wr && sel_hit(idx, `CCBT_IDX_COUNTER))
                timer_counter_value <= avs_writedata[15:0];
            else if (running)
            begin
                timer_counter_value <= cnt_next;
                dn_reg <= reset_hit ? 1'b0 : dn_next;
                if (bt_tick)
                begin
                    if (reset_hit)
                        ch0_pend_reg <= 2'h0;
                    else if (ch0_pend_reg != 2'h0)
                        ch0_pend_reg <= ch0_pend_reg + 2'h1;
                    else if (chan0_match_reset_en
                        && timer_counter_value == chan0_compare_value)
                        ch0_pend_reg <= 2'h1;
                end
            end
            if (irq_set && running)
                irq_flag_reg <= 1'b1;
            else if (wr && sel_hit(idx, `CCBT_IDX_STATUS) && avs_writedata[`CCBT_S_IRQ])
                irq_flag_reg <= 1'b0;
            if (wr && sel_hit(idx, `CCBT_IDX_CTRL0))
            begin
                count_source_sel <= avs_writedata[`CCBT_C0_SRC_HI:`CCBT_C0_SRC_LO];
                reset_reg_reset_en <= avs_writedata[`CCBT_C0_RSTREG];
                overflow_bit_sel <= avs_writedata[`CCBT_C0_OVSEL];
            end
            if (wr && sel_hit(idx, `CCBT_IDX_CTRL1))
            begin
                timer_run <= avs_writedata[`CCBT_C1_RUN];
                chan0_match_reset_en <= avs_writedata[`CCBT_C1_CH0RST];
                ext_pin_reset_en <= avs_writedata[`CCBT_C1_EXTRST];
                count_direction_mode <= avs_writedata[`CCBT_C1_DIR_HI:`CCBT_C1_DIR_LO];
            end
            if (wr && sel_hit(idx, `CCBT_IDX_DIVIDER))
                divide_setting <= avs_writedata[DIV_W-1:0];
            if (wr && sel_hit(idx, `CCBT_IDX_RESETCMP))
                reset_compare_value <= avs_writedata[15:0];
            if (wr && sel_hit(idx, `CCBT_IDX_CH0CMP))
                chan0_compare_value <= avs_writedata[15:0];
            if (wr && sel_hit(idx, `CCBT_IDX_CH0WAVE))
            begin
                waveform_mode <= avs_writedata[`CCBT_W_MODE_HI:`CCBT_W_MODE_LO];
                output_invert_en <= avs_writedata[`CCBT_W_INV];
                default_level <= avs_writedata[`CCBT_W_LVL];
            end
            if (wr && sel_hit(idx, `CCBT_IDX_CH0WAVE + 4'h8)
                && waveform_mode != `CCBT_WAVE_SR)
                chan1_mode_reg <= avs_writedata[`CCBT_W_MODE_HI:`CCBT_W_MODE_LO];
            if (wr && sel_hit(idx, `CCBT_IDX_FUNC))
            begin
                chan_function_sel <= avs_writedata[`CCBT_F_SEL];
                chan_enable <= avs_writedata[`CCBT_F_EN];
            end
            if (wr && sel_hit(idx, `CCBT_IDX_PRESC))
            begin
                presc_div_reg <= avs_writedata[DIV_W-1:0];
                prescale_en <= avs_writedata[`CCBT_P_EN];
            end
        end
    end
    // ----------------------------------------
    // channel 0 waveform and capture prescaler
    // ----------------------------------------
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            wave_reg <= 1'b0;
            chan0_out <= 1'b0;
            chan1_out <= 1'b0;
            presc_cnt_reg <= {DIV_W{1'b0}};
            capture_tick <= 1'b0;
            timer_irq <= 1'b0;
        end
        else
        begin
            timer_irq <= irq_flag_reg;
            // ch0 toggles on match unless it serves as the reset period
            if (!(chan_enable && !chan_function_sel))
                wave_reg <= default_level;
            else if (wr && sel_hit(idx, `CCBT_IDX_CH0WAVE))
                wave_reg <= avs_writedata[`CCBT_W_LVL];
            else if (bt_tick && !chan0_match_reset_en
                && timer_counter_value == chan0_compare_value)
                wave_reg <= ~wave_reg;
            chan0_out <= wave_reg ^ output_invert_en;
            chan1_out <= 1'b0;
            capture_tick <= 1'b0;
            if (!prescale_en)
                presc_cnt_reg <= {DIV_W{1'b0}};
            else if (bt_tick && a_sync)
            begin
                // first interval is presc_div_reg+1 ticks like the rest because count starts at 0
                if (presc_cnt_reg >= presc_div_reg)
                begin
                    presc_cnt_reg <= {DIV_W{1'b0}};
                    capture_tick <= 1'b1;
                end
                else
                    presc_cnt_reg <= presc_cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
            end
        end
    end
    // ----------------------------------------
    // avalon slave, one wait cycle
    // ----------------------------------------
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            avs_readdata <= 32'h00000000;
            avs_waitrequest <= 1'b1;
        end
        else
        begin
            avs_waitrequest <= ~acc;
            if (acc && avs_read)
            begin
                avs_readdata <= 32'h00000000;
                if (sel_hit(idx, `CCBT_IDX_COUNTER))
                    avs_readdata[15:0] <= timer_counter_value;
                else if (sel_hit(idx, `CCBT_IDX_CTRL0))
                    avs_readdata[3:0] <= {overflow_bit_sel, reset_reg_reset_en,
                        count_source_sel};
                else if (sel_hit(idx, `CCBT_IDX_CTRL1))
                    avs_readdata[4:0] <= {count_direction_mode, ext_pin_reset_en,
                        chan0_match_reset_en, timer_run};
                else if (sel_hit(idx, `CCBT_IDX_DIVIDER))
                    avs_readdata[DIV_W-1:0] <= divide_setting;
                else if (sel_hit(idx, `CCBT_IDX_RESETCMP))
                    avs_readdata[15:0] <= reset_compare_value;
                else if (sel_hit(idx, `CCBT_IDX_CH0CMP))
                    avs_readdata[15:0] <= chan0_compare_value;
                else if (sel_hit(idx, `CCBT_IDX_CH0WAVE))
                    avs_readdata[3:0] <= {default_level, output_invert_en, waveform_mode};
                else if (sel_hit(idx, `CCBT_IDX_FUNC))
                    avs_readdata[1:0] <= {chan_enable, chan_function_sel};
                else if (sel_hit(idx, `CCBT_IDX_STATUS))
                    avs_readdata[0] <= irq_flag_reg;
                else if (sel_hit(idx, `CCBT_IDX_PRESC))
                    avs_readdata[8:0] <= {prescale_en, presc_div_reg};
            end
        end
    end
endmodule // ccbt_base_timer

// *** test/ccbt_checker.sv ***
`timescale 1ns/1ps
module ccbt_checker (
    input wire core_clk,
    input wire rst,
    input wire [5:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire ext_reset_pin,
    input wire quad_input_a,
    input wire quad_input_b,
    input wire timer_irq,
    input wire chan0_out,
    input wire chan1_out,
    input wire capture_tick
);
default clocking cb @(posedge core_clk);
endclocking
default disable iff (rst);
// ------
// bus answer and port checks
// ------
sequence s_read_done;
    $fell(avs_waitrequest) && $past(avs_read);
endsequence
property p_answer_next;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
endproperty
a_answer_next: assert property (p_answer_next) else $error("late answer");
property p_answer_once;
    !avs_waitrequest |=> avs_waitrequest;
endproperty
a_answer_once: assert property (p_answer_once) else $error("answer too long");
property p_answer_caused;
    $fell(avs_waitrequest) |-> $past(avs_read || avs_write);
endproperty
a_answer_caused: assert property (p_answer_caused) else $error("answer unasked");
property p_odd_silent;
    !chan1_out;
endproperty
a_odd_silent: assert property (p_odd_silent) else $error("odd channel drives");
property p_unmapped;
    s_read_done ##0 ($past(avs_address[5:2]) > 4'h9) |-> avs_readdata == 32'h0;
endproperty
a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
property p_count_width;
    s_read_done ##0 ($past(avs_address[5:2]) == 4'h0) |-> avs_readdata[31:16] == 16'h0;
endproperty
a_count_width: assert property (p_count_width) else $error("counter too wide");
property p_irq_status;
    s_read_done ##0 ($past(avs_address[5:2]) == 4'h8) |-> avs_readdata[0] == timer_irq;
endproperty
a_irq_status: assert property (p_irq_status) else $error("irq and flag differ");
property p_read_hold;
    !avs_read |=> $stable(avs_readdata);
endproperty
a_read_hold: assert property (p_read_hold) else $error("read data moved");
endmodule // ccbt_checker
bind ccbt_base_timer ccbt_checker u_chk (.core_clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .ext_reset_pin,
    .quad_input_a, .quad_input_b, .timer_irq, .chan0_out, .chan1_out, .capture_tick);

// *** test/ccbt_encoder_model.sv ***
`timescale 1ns/1ps
module ccbt_encoder_model (
    input wire core_clk,
    input wire rst,
    input wire step_req,
    input wire step_dir,
    input wire pin_low,
    output reg quad_input_a,
    output reg quad_input_b,
    output reg ext_reset_pin
);
reg [1:0] phase_reg;
// ------
// gray phase walk and pulled-up pin
// ------
always @(posedge core_clk or posedge rst)
begin
    if (rst)
        phase_reg <= 2'b00;
    else if (step_req)
        phase_reg <= step_dir ? phase_reg - 2'd1 : phase_reg + 2'd1;
end
always @*
begin
    quad_input_a = phase_reg[1];
    quad_input_b = phase_reg[1] ^ phase_reg[0];
    ext_reset_pin = !pin_low;
end
endmodule // ccbt_encoder_model

// *** test/ccbt_base_timer_tb_top.sv ***
`timescale 1ns/1ps
module ccbt_base_timer_tb_top;
reg core_clk = 1'b0;
reg rst = 1'b1;
reg [5:0] avs_address = 6'h00;
reg avs_read = 1'b0;
reg avs_write = 1'b0;
reg [31:0] avs_writedata = 32'h0;
reg [3:0] avs_byteenable = 4'hf;
reg step_req = 1'b0;
reg step_dir = 1'b0;
reg pin_low = 1'b0;
wire [31:0] avs_readdata;
wire avs_waitrequest, ext_reset_pin, quad_input_a, quad_input_b;
wire timer_irq, chan0_out, chan1_out, capture_tick;
integer fails = 0;
integer compares = 0;
integer seed = 76;
integer i;
reg [31:0] a, b;
reg [15:0] r;
reg [1:0] irqs;
always #12.5 core_clk = ~core_clk;
ccbt_base_timer u_dut (.core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .ext_reset_pin, .quad_input_a,
    .quad_input_b, .timer_irq, .chan0_out, .chan1_out, .capture_tick);
ccbt_encoder_model u_enc (.core_clk, .rst, .step_req, .step_dir, .pin_low, .quad_input_a,
    .quad_input_b, .ext_reset_pin);
// ------
// bench tasks and expectations
// ------
function integer gap(input integer ticks, input integer per);
    gap = ticks * per - 3;
endfunction
task complete_run;
begin
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
        $display("STATUS OK");
    else
        $display("STATUS NOT OK");
    $finish;
end
endtask
task check(input [8*6-1:0] nm, input [31:0] seen, input [31:0] exp);
begin
    compares = compares + 1;
    if (seen !== exp)
    begin
        fails = fails + 1;
        $display("Error %0s expected %h seen %h", nm, exp, seen);
    end
end
endtask
task bus(input wr_en, input [5:0] adr, input [31:0] wd);
integer k;
begin
    k = 0;
    @(posedge core_clk);
    avs_address <= adr;
    avs_writedata <= wd;
    avs_write <= wr_en;
    avs_read <= !wr_en;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0 && k < 40)
    begin
        k = k + 1;
        @(posedge core_clk);
    end
    if (avs_waitrequest !== 1'b0)
    begin
        fails = fails + 1;
        complete_run;
    end
    else
    begin
        a = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    end
end
endtask
task wr(input [5:0] adr, input [31:0] wd);
    bus(1'b1, adr, wd);
endtask
task rd(input [5:0] adr);
    bus(1'b0, adr, 32'h0);
endtask
task steps(input dir);
integer k;
begin
    for (k = 0; k < 8; k = k + 1)
    begin
        step_dir <= dir;
        step_req <= 1'b1;
        @(posedge core_clk);
        step_req <= 1'b0;
        repeat (4 + {$random(seed)} % 6) @(posedge core_clk);
    end
    repeat (8) @(posedge core_clk);
end
endtask
task period(input integer per);
begin
    rd(6'h00);
    b = a;
    repeat (gap(4, per)) @(posedge core_clk);
    rd(6'h00);
end
endtask
initial
begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    wr(6'h00, 32'h1234);
    wr(6'h08, 32'h1);
    rd(6'h00);
    check("hold", a, 32'h0);
    b = $random(seed) & 32'hffff;
    wr(6'h00, b);
    repeat (20) @(posedge core_clk);
    rd(6'h00);
    check("load", a, b);
    rd(6'h28);
    $display("test hold done");
    for (i = 0; i < 3; i = i + 1)
    begin
        r = (i == 0) ? 16'd0 : (i == 1) ? 16'd255 : 16'd1 + {$random(seed)} % 254;
        wr(6'h0c, {16'h0, r});
        wr(6'h04, 32'h1);
        rd(6'h00);
        b = a;
        repeat (gap(16, r + 1)) @(posedge core_clk);
        rd(6'h00);
        check("div", (a - b) & 32'hffff, 32'd16);
    end
    $display("test divide done");
    wr(6'h0c, 32'h0);
    wr(6'h20, 32'h1);
    wr(6'h00, 32'hfff8);
    repeat (20) @(posedge core_clk);
    rd(6'h00);
    check("wrap", a < 32'h40, 32'h1);
    rd(6'h20);
    check("ovf", a[0], 32'h1);
    check("irq", timer_irq, 32'h1);
    for (i = 0; i < 2; i = i + 1)
    begin
        wr(6'h04, {i[0], 3'b001});
        wr(6'h20, 32'h1);
        wr(6'h00, 32'h7ff8);
        repeat (20) @(posedge core_clk);
        rd(6'h20);
        irqs[i] = a[0];
    end
    check("ovsel", irqs[0] ^ irqs[1], 32'h1);
    $display("test overflow done");
    wr(6'h04, 32'h1);
    wr(6'h08, 32'h9);
    for (i = 0; i < 2; i = i + 1)
    begin
        wr(6'h00, i ? 32'h8 : 32'hfff0);
        repeat (40) @(posedge core_clk);
        rd(6'h00);
        b = a;
        repeat (13) @(posedge core_clk);
        rd(6'h00);
        check("updn", (i ? a - b : b - a) & 32'hffff, 32'd16);
    end
    $display("test updown done");
    r = 16'h10 + {$random(seed)} % 64;
    wr(6'h08, 32'h1);
    wr(6'h10, {16'h0, r});
    wr(6'h04, 32'h5);
    wr(6'h00, 32'h0);
    wr(6'h20, 32'h1);
    period(r + 1);
    check("rcmp", a, b);
    check("rmax", a <= r, 32'h1);
    rd(6'h20);
    check("rirq", a[0], 32'h1);
    wr(6'h04, 32'h1);
    wr(6'h18, 32'h0);
    wr(6'h14, {16'h0, r});
    wr(6'h1c, 32'h2);
    wr(6'h08, 32'h3);
    wr(6'h00, 32'h0);
    period(r + 3);
    check("c0rst", a, b);
    check("c0max", a <= r + 2, 32'h1);
    $display("test compare done");
    wr(6'h08, 32'h5);
    pin_low <= 1'b1;
    repeat (8) @(posedge core_clk);
    rd(6'h00);
    check("pin", a, 32'h0);
    pin_low <= 1'b0;
    repeat (8) @(posedge core_clk);
    rd(6'h00);
    check("pinup", a != 0, 32'h1);
    $display("test pin done");
    wr(6'h04, 32'h2);
    wr(6'h08, 32'h11);
    wr(6'h00, 32'h100);
    steps(1'b0);
    rd(6'h00);
    check("qfwd", a == 32'h108 || a == 32'hf8, 32'h1);
    steps(1'b1);
    rd(6'h00);
    check("qback", a, 32'h100);
    $display("test quad done");
    wr(6'h08, 32'h0);
    wr(6'h1c, 32'h2);
    for (i = 0; i < 4; i = i + 1)
    begin
        wr(6'h18, {i[1:0], 2'b00});
        repeat (3) @(posedge core_clk);
        check("level", chan0_out, i[1] ^ i[0]);
    end
    wr(6'h18, 32'h3);
    wr(6'h38, 32'h0);
    wr(6'h08, 32'h1);
    repeat (10) @(posedge core_clk);
    check("odd", chan1_out, 32'h0);
    $display("test wave done");
    step_req <= 1'b1;
    repeat (2) @(posedge core_clk);
    step_req <= 1'b0;
    wr(6'h04, 32'h1);
    wr(6'h24, 32'h103);
    b = 0;
    repeat (40)
    begin
        @(posedge core_clk);
        b = b + capture_tick;
    end
    check("presc", b, 32'd10);
    $display("test presc done");
    complete_run;
end
endmodule // ccbt_base_timer_tb_top
